/* File: design/uat_pkg.sv */
// Shared constants and types of the asynchronous serial transmitter.
// Assumes an 8-bit register port and an external baud tick source.
package uat_pkg;

    // Register offsets on the 3-bit register port
    localparam logic [2:0] UAT_OFF_TXCTL   = 3'h0;
    localparam logic [2:0] UAT_OFF_PORTCTL = 3'h1;
    localparam logic [2:0] UAT_OFF_BAUDCTL = 3'h2;
    localparam logic [2:0] UAT_OFF_DIV_LO  = 3'h3;
    localparam logic [2:0] UAT_OFF_DIV_HI  = 3'h4;
    localparam logic [2:0] UAT_OFF_TXHOLD  = 3'h5;
    localparam logic [2:0] UAT_OFF_IRQ_EN  = 3'h6;
    localparam logic [2:0] UAT_OFF_IRQ_FLG = 3'h7;

    // Field positions
    localparam int unsigned UAT_TXC_NINE_SEL    = 6;
    localparam int unsigned UAT_TXC_TX_EN       = 5;
    localparam int unsigned UAT_TXC_SYNC        = 4;
    localparam int unsigned UAT_TXC_HI_SPEED    = 2;
    localparam int unsigned UAT_TXC_SH_EMPTY    = 1;
    localparam int unsigned UAT_TXC_NINTH       = 0;
    localparam int unsigned UAT_PC_PORT_EN      = 7;
    localparam int unsigned UAT_BAUD_POL_INV    = 4;
    localparam int unsigned UAT_BAUD_WIDE_DIV   = 3;
    localparam int unsigned UAT_IRQ_TX_IE       = 0;
    localparam int unsigned UAT_IRQ_PERIPH_IE   = 1;
    localparam int unsigned UAT_IRQ_GLOBAL_IE   = 2;
    localparam int unsigned UAT_FLG_TX_EMPTY    = 0;

    // Writable masks; the read-only shifter-empty bit stays out, but unused bits 7 and 3 of TXCTL and 1:0 of BAUDCTL stay in
    localparam logic [7:0] UAT_TXC_WMASK     = 8'hFD;
    localparam logic [7:0] UAT_BAUD_WMASK    = 8'h1B;
    localparam logic [7:0] UAT_IRQ_EN_WMASK  = 8'h07;

    // Reset values
    localparam logic [7:0] UAT_REG_RST       = 8'h00;
    localparam logic [8:0] UAT_CHAR_RST      = 9'h000;

    // Character carried from holding register to shifter
    typedef struct packed {
        logic       nine;
        logic [8:0] bits;
    } uat_char_t;

    // Shifter phases, one-hot
    typedef enum logic [3:0] {
        UAT_SH_IDLE  = 4'b0001,
        UAT_SH_START = 4'b0010,
        UAT_SH_DATA  = 4'b0100,
        UAT_SH_STOP  = 4'b1000
    } uat_sh_state_t;

endpackage

/* File: design/uat_hold.sv */
// One-deep transmit holding register.
// Assumes the owner never asks to take while it is empty.
`timescale 1ns/100ps
module uat_hold
    import uat_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_b_i,
    // Control
    input  wire logic      clear_i,
    input  wire logic      put_i,
    input  wire uat_char_t put_char_i,
    input  wire logic      take_i,
    // Status and data
    output logic           full_o,
    output uat_char_t      char_o
);
    typedef struct packed {
        logic      full;
        uat_char_t chr;
    } uat_hold_st_t;

    uat_hold_st_t st;
    uat_hold_st_t next_st;

    always_comb begin
        next_st = st;
        if (take_i) begin
            next_st.full = 1'b0;
        end
        // A put in the take cycle queues the next character
        if (put_i) begin
            next_st.full = 1'b1;
            next_st.chr  = put_char_i;
        end
        if (clear_i) begin
            next_st.full = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{full: 1'b0, chr: '{nine: 1'b0, bits: UAT_CHAR_RST}};
        end else begin
            st <= next_st;
        end
    end

    assign full_o = st.full;
    assign char_o = st.chr;
endmodule

/* File: design/uat_shifter.sv */
// Frame shifter: start bit, 8 or 9 data bits LSB first, one stop bit.
// Assumes tick_i is a one-cycle pulse per baud period.
`timescale 1ns/100ps
module uat_shifter
    import uat_pkg::*;
#(
    parameter int unsigned MAX_BITS = 9
)(
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_b_i,
    // Control
    input  wire logic      clear_i,
    input  wire logic      tick_i,
    input  wire logic      load_i,
    input  wire uat_char_t char_i,
    // Line side, true polarity
    output logic           busy_o,
    output logic           line_o
);
    typedef struct packed {
        uat_sh_state_t       state;
        logic [MAX_BITS-1:0] sreg;
        logic [3:0]          left;
        logic                line;
    } uat_sh_st_t;

    uat_sh_st_t st;
    uat_sh_st_t next_st;

    always_comb begin
        next_st = st;
        case (st.state)
            UAT_SH_IDLE: begin
                next_st.line = 1'b1;
            end
            UAT_SH_START: begin
                if (tick_i) begin
                    next_st.state = UAT_SH_DATA;
                    next_st.line  = st.sreg[0];
                end
            end
            UAT_SH_DATA: begin
                if (tick_i) begin
                    next_st.sreg = {1'b0, st.sreg[MAX_BITS-1:1]};
                    next_st.left = st.left - 4'h1;
                    if (st.left == 4'h1) begin
                        next_st.state = UAT_SH_STOP;
                        next_st.line  = 1'b1;
                    end else begin
                        next_st.line = st.sreg[1];
                    end
                end
            end
            UAT_SH_STOP: begin
                if (tick_i) begin
                    next_st.state = UAT_SH_IDLE;
                end
            end
            default: begin
                next_st.state = UAT_SH_IDLE;
                next_st.line  = 1'b1;
            end
        endcase
        // Start bit goes out on the load edge itself
        if (load_i) begin
            next_st.state = UAT_SH_START;
            next_st.sreg  = char_i.bits;
            next_st.left  = char_i.nine ? 4'h9 : 4'h8;
            next_st.line  = 1'b0;
        end
        if (clear_i) begin
            next_st.state = UAT_SH_IDLE;
            next_st.line  = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{state: UAT_SH_IDLE, sreg: '0, left: 4'h0, line: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = (st.state != UAT_SH_IDLE);
    assign line_o = st.line;
endmodule

/* File: design/uat_tx.sv */
// Asynchronous serial transmitter top: register port, holding register,
// frame shifter, pin drive and interrupt request.
// Assumes a one-cycle baud tick from an outside rate generator and
// register strobes synchronous to clk_i.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - Transmitter runs only with transmit enable 1, sync 0, port enable 1.
// - Port enable turns the serial pin into a driven output.
// - Setting transmit enable sets the buffer-empty flag.
// - Holding write moves straight to shifter when shifter is empty.
// - Queued character moves to shifter one cycle after stop bit.
// - Start bit begins right as a character enters the shifter.
// - Polarity bit 0 gives high-true line, 1 inverts it.
// - Polarity bit inverts transmit data only in asynchronous mode.
// - Buffer-empty flag set whenever enabled and holding register empty.
// - Flag does not drop in write cycle; valid two cycles later.
// - Buffer-empty flag is read-only to software.
// - Flag ignores interrupt enable; enable only gates the request.
// - Request rises at once when enables and flag are all set.
// - Shifter-empty bit clears on load, sets after last bit out.
// - Shifter-empty bit raises no interrupt; software polls it.
// - Nine-bit mode sends nine data bits, ninth bit most significant.
// - Ninth bit written first; all nine bits move on holding write.
// - Frame is low start, data, high stop; idle high; one bit per baud. Here the start bit lasts only from the load to the next tick.
// - Data bits go out least significant first.
module uat_tx
    import uat_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Baud rate generator side
    input  wire logic        baud_tick_i,
    output logic      [15:0] baud_divisor_o,
    output logic             high_speed_baud_o,
    output logic             wide_baud_divisor_o,
    // Serial pin
    output logic             serial_out_o,
    output logic             serial_out_oe_b_o,
    // Interrupt request
    output logic             tx_irq_o
);
    typedef struct packed {
        logic [7:0] tx_ctl;
        logic [7:0] port_ctl;
        logic [7:0] baud_ctl;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] hold_shadow;
        logic [7:0] irq_en;
        logic       tx_empty_flag;
        logic [7:0] rdata;
        logic       pin;
        logic       pin_oe_b;
    } uat_top_st_t;

    uat_top_st_t st;
    uat_top_st_t next_st;

    uat_char_t hold_char;
    uat_char_t put_char;
    logic      hold_full;
    logic      sh_busy;
    logic      sh_line;
    logic      tx_on;
    logic      load;
    logic      hold_wr;
    logic      async_mode;
    logic      pol_inv;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        return a == off;
    endfunction

    assign async_mode = !st.tx_ctl[UAT_TXC_SYNC];
    assign tx_on      = st.tx_ctl[UAT_TXC_TX_EN] && async_mode
                        && st.port_ctl[UAT_PC_PORT_EN];
    // Writes with the transmitter off are dropped, not queued
    assign hold_wr    = wr_i && hit(addr_i, UAT_OFF_TXHOLD) && tx_on;
    // Ninth bit is taken from the status register at write time
    assign put_char = '{nine: st.tx_ctl[UAT_TXC_NINE_SEL],
                        bits: {st.tx_ctl[UAT_TXC_NINTH],
                               wdata_i}};
    // Move as soon as the shifter is free, one cycle past stop
    assign load    = hold_full && !sh_busy && tx_on;
    assign pol_inv = st.baud_ctl[UAT_BAUD_POL_INV]
                     && async_mode;

    uat_hold u_hold (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .clear_i    (!tx_on),
        .put_i      (hold_wr),
        .put_char_i (put_char),
        .take_i     (load),
        .full_o     (hold_full),
        .char_o     (hold_char)
    );

    uat_shifter #(
        .MAX_BITS (9)
    ) u_shifter (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .clear_i (!tx_on),
        .tick_i  (baud_tick_i),
        .load_i  (load),
        .char_i  (hold_char),
        .busy_o  (sh_busy),
        .line_o  (sh_line)
    );

    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (wr_i) begin
            case (addr_i)
                UAT_OFF_TXCTL: begin
                    next_st.tx_ctl = wdata_i & UAT_TXC_WMASK;
                end
                UAT_OFF_PORTCTL: begin
                    next_st.port_ctl = wdata_i;
                end
                UAT_OFF_BAUDCTL: begin
                    next_st.baud_ctl = wdata_i & UAT_BAUD_WMASK;
                end
                UAT_OFF_DIV_LO: begin
                    next_st.div_lo = wdata_i;
                end
                UAT_OFF_DIV_HI: begin
                    next_st.div_hi = wdata_i;
                end
                UAT_OFF_TXHOLD: begin
                    next_st.hold_shadow = wdata_i;
                end
                UAT_OFF_IRQ_EN: begin
                    next_st.irq_en = wdata_i & UAT_IRQ_EN_WMASK;
                end
                // Flag register ignores writes
                default: begin
                    next_st.tx_ctl = st.tx_ctl;
                end
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                UAT_OFF_TXCTL: begin
                    next_st.rdata = st.tx_ctl;
                    // Polled only, no request path
                    next_st.rdata[UAT_TXC_SH_EMPTY] =
                        !sh_busy;
                end
                UAT_OFF_PORTCTL: begin
                    next_st.rdata = st.port_ctl;
                end
                UAT_OFF_BAUDCTL: begin
                    next_st.rdata = st.baud_ctl;
                end
                UAT_OFF_DIV_LO: begin
                    next_st.rdata = st.div_lo;
                end
                UAT_OFF_DIV_HI: begin
                    next_st.rdata = st.div_hi;
                end
                UAT_OFF_TXHOLD: begin
                    next_st.rdata = st.hold_shadow;
                end
                UAT_OFF_IRQ_EN: begin
                    next_st.rdata = st.irq_en;
                end
                default: begin
                    next_st.rdata[UAT_FLG_TX_EMPTY] = st.tx_empty_flag;
                end
            endcase
        end
        // Flag sees the holding state one cycle late, so it drops on the
        // second edge after a write; polling earlier reads stale state
        next_st.tx_empty_flag = tx_on && !hold_full;
        next_st.pin_oe_b      = !st.port_ctl[UAT_PC_PORT_EN];
        next_st.pin           = sh_line ^ pol_inv;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{tx_ctl: UAT_REG_RST, port_ctl: UAT_REG_RST,
                    baud_ctl: UAT_REG_RST, div_lo: UAT_REG_RST,
                    div_hi: UAT_REG_RST, hold_shadow: UAT_REG_RST,
                    irq_en: UAT_REG_RST, tx_empty_flag: 1'b0,
                    rdata: UAT_REG_RST, pin: 1'b1, pin_oe_b: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o             = st.rdata;
    assign baud_divisor_o      = {st.div_hi, st.div_lo};
    assign high_speed_baud_o   = st.tx_ctl[UAT_TXC_HI_SPEED];
    assign wide_baud_divisor_o = st.baud_ctl[UAT_BAUD_WIDE_DIV];
    assign serial_out_o        = st.pin;
    assign serial_out_oe_b_o   = st.pin_oe_b;
    // Request follows the flag with no extra latency
    assign tx_irq_o = st.tx_empty_flag && st.irq_en[UAT_IRQ_TX_IE]
                      && st.irq_en[UAT_IRQ_PERIPH_IE]
                      && st.irq_en[UAT_IRQ_GLOBAL_IE];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_load;
        load;
    endsequence

    sequence s_start_out;
        ##1 !sh_line ##1 (serial_out_o == pol_inv);
    endsequence

    property p_start_follows_load;
        s_load |-> s_start_out;
    endproperty

    a_pin_drive: assert property (
        ##1 (serial_out_oe_b_o == !$past(st.port_ctl[UAT_PC_PORT_EN])))
        else $error("pin enable does not follow port enable");

    a_flag_on_enable: assert property (
        $rose(tx_on) |=> st.tx_empty_flag)
        else $error("flag not set after transmitter enable");

    a_flag_write_lag: assert property (
        (hold_wr && st.tx_empty_flag) |=> st.tx_empty_flag)
        else $error("flag cleared too early after write");

    a_flag_queued: assert property (
        (hold_full && sh_busy) |=> !st.tx_empty_flag)
        else $error("flag set while a character is queued");

    a_load_moves: assert property (
        load |=> sh_busy && !$stable(sh_busy) or $past(sh_busy))
        else $error("shifter not busy after load");

    a_start_bit: assert property (
        p_start_follows_load)
        else $error("start bit missing after load");

    a_stop_to_load: assert property (
        ($fell(sh_busy) && hold_full && tx_on) |-> load ##1 sh_busy)
        else $error("queued character not moved after stop");

    a_idle_level: assert property (
        (!sh_busy && !load) [*2] |-> (serial_out_o == !pol_inv)
            or $changed(pol_inv) or $past(load))
        else $error("idle line level wrong");

    a_empty_clear: assert property (
        (rd_i && hit(addr_i, UAT_OFF_TXCTL) && sh_busy)
            |=> !rdata_o[UAT_TXC_SH_EMPTY])
        else $error("shifter-empty bit set while busy");

    a_irq_gate: assert property (
        !st.irq_en[UAT_IRQ_TX_IE] |-> !tx_irq_o)
        else $error("request raised with interrupt disabled");
endmodule

/* File: verif/uat_rx_model.sv */
// Remote serial receiver model: samples the line mid-bit between ticks.
// Assumes frames start just after a baud tick, ticks every TDIV cycles.
`timescale 1ns/100ps
module uat_rx_model #(
    parameter int unsigned TDIV = 8
)(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Line and format
    input  wire logic       tick_i,
    input  wire logic       line_i,
    input  wire logic       pol_i,
    input  wire logic       nine_i,
    // Received character
    output logic            got_o,
    output logic      [8:0] data_o,
    output logic            stop_ok_o
);
    logic [3:0] ph;
    logic [3:0] n;
    logic       act;
    logic [8:0] sh;
    logic       ln;

    assign ln = line_i ^ pol_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph        <= 4'h0;
            n         <= 4'h0;
            act       <= 1'b0;
            sh        <= 9'h000;
            got_o     <= 1'b0;
            data_o    <= 9'h000;
            stop_ok_o <= 1'b0;
        end else begin
            got_o <= 1'b0;
            ph    <= tick_i ? 4'h0 : ph + 4'h1;
            // Mid-bit sampling tolerates a cycle or two of line lag
            if (ph == 4'(TDIV / 2)) begin
                if (!act) begin
                    act <= !ln;
                    n   <= 4'h0;
                    sh  <= 9'h000;
                end else if (n < (nine_i ? 4'h9 : 4'h8)) begin
                    sh[n] <= ln;
                    n     <= n + 4'h1;
                end else begin
                    act       <= 1'b0;
                    got_o     <= 1'b1;
                    data_o    <= sh; // Bit 8 marks an address
                    stop_ok_o <= ln;
                end
            end
        end
    end
endmodule

/* File: verif/uat_tx_tb_top.sv */
// Testbench of the serial transmitter: register tasks and line receiver.
// Assumes baud ticks made here every TDIV cycles and the uat_pkg map.
`timescale 1ns/100ps
module uat_tx_tb_top import uat_pkg::*;;
    localparam int unsigned TDIV = 8;
    logic        clk_i;
    logic        rst_b_i;
    logic [2:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic        baud_tick_i;
    logic [15:0] baud_divisor_o;
    logic        high_speed_baud_o;
    logic        wide_baud_divisor_o;
    logic        serial_out_o;
    logic        serial_out_oe_b_o;
    logic        tx_irq_o;
    logic        pol;
    logic        nine;
    logic        got;
    logic        stop_ok;
    logic [8:0]  rx_data;
    logic [8:0]  rxq[$];
    int          fails = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          tc = 0;

    uat_tx i_uat_tx (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .baud_tick_i(baud_tick_i), .baud_divisor_o(baud_divisor_o),
        .high_speed_baud_o(high_speed_baud_o),
        .wide_baud_divisor_o(wide_baud_divisor_o),
        .serial_out_o(serial_out_o),
        .serial_out_oe_b_o(serial_out_oe_b_o), .tx_irq_o(tx_irq_o));

    uat_rx_model #(.TDIV(TDIV)) i_uat_rx_model (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .tick_i(baud_tick_i), .line_i(serial_out_o),
        .pol_i(pol), .nine_i(nine), .got_o(got), .data_o(rx_data),
        .stop_ok_o(stop_ok));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Baud tick stands in for the outside rate generator
    always @(posedge clk_i) begin
        tc          <= (tc == TDIV - 1) ? 0 : tc + 1;
        baud_tick_i <= (tc == TDIV - 2);
        cyc         <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            summarize();
        end
        if (got === 1'b1) begin
            rxq.push_back(rx_data);
            chk("stop bit", 16'h0001, {15'h0000, stop_ok});
        end
    end

    task automatic summarize;
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] e,
                         input string nm);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, rdata_o});
    endtask

    // Writes land just after a tick so the start bit spans a mid sample
    task automatic send(input logic [7:0] d);
        do @(posedge clk_i); while (baud_tick_i !== 1'b1);
        wr(UAT_OFF_TXHOLD, d);
    endtask

    task automatic rx(input int n, input logic [8:0] e);
        int k;
        for (k = 0; k < 400 && rxq.size() < n; k++) @(posedge clk_i);
        chk("rx count", 16'(n), 16'(rxq.size()));
        if (rxq.size() >= n) chk("rx char", {7'h00, e}, {7'h00, rxq[n-1]});
    endtask

    initial begin
        rst_b_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        baud_tick_i = 1'b0;
        pol = 1'b0;
        nine = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk("idle line", 16'h0001, {15'h0000, serial_out_o});
        chk("pin off", 16'h0001, {15'h0000, serial_out_oe_b_o});
        rdchk(UAT_OFF_TXCTL, 8'h02, "tx control reset");
        rdchk(UAT_OFF_IRQ_FLG, 8'h00, "flag reset");
        wr(UAT_OFF_DIV_LO, 8'h34);
        wr(UAT_OFF_DIV_HI, 8'h12);
        wr(UAT_OFF_TXCTL, 8'h04);
        // Pin enable is registered, so port enable goes in first
        wr(UAT_OFF_PORTCTL, 8'h80);
        wr(UAT_OFF_BAUDCTL, 8'hE8);
        chk("divisor", 16'h1234, baud_divisor_o);
        chk("speed", 16'h0003, {14'h0, high_speed_baud_o,
            wide_baud_divisor_o});
        chk("pin on", 16'h0000, {15'h0000, serial_out_oe_b_o});
        rdchk(UAT_OFF_BAUDCTL, 8'h08, "baud control mask");
        rdchk(UAT_OFF_IRQ_FLG, 8'h00, "flag no enable");
        wr(UAT_OFF_TXCTL, 8'h24);
        rdchk(UAT_OFF_IRQ_FLG, 8'h01, "flag enabled");
        wr(UAT_OFF_IRQ_FLG, 8'h00);
        rdchk(UAT_OFF_IRQ_FLG, 8'h01, "flag written");
        wr(UAT_OFF_IRQ_EN, 8'h06);
        chk("irq gated", 16'h0000, {15'h0000, tx_irq_o});
        wr(UAT_OFF_IRQ_EN, 8'h07);
        chk("irq", 16'h0001, {15'h0000, tx_irq_o});
        // Enable dropped before the first character
        wr(UAT_OFF_IRQ_EN, 8'h06);
        send(8'hA5);
        rdchk(UAT_OFF_TXCTL, 8'h24, "shifter busy");
        rx(1, 9'h0A5);
        repeat (TDIV) @(posedge clk_i);
        rdchk(UAT_OFF_TXCTL, 8'h26, "shifter idle");
        chk("no irq", 16'h0000, {15'h0000, tx_irq_o});
        send(8'h0F);
        wr(UAT_OFF_TXHOLD, 8'hF0);
        @(posedge clk_i);
        rdchk(UAT_OFF_IRQ_FLG, 8'h00, "flag queued");
        rx(2, 9'h00F);
        rx(3, 9'h0F0);
        rdchk(UAT_OFF_IRQ_FLG, 8'h01, "flag drained");
        wr(UAT_OFF_TXCTL, 8'h65);
        nine = 1'b1;
        send(8'h3C);
        rx(4, 9'h13C);
        wr(UAT_OFF_TXCTL, 8'h64);
        send(8'hC3);
        rx(5, 9'h0C3);
        wr(UAT_OFF_TXCTL, 8'h24);
        nine = 1'b0;
        send(8'h18);
        rx(6, 9'h018);
        do @(posedge clk_i); while (baud_tick_i !== 1'b1);
        wr(UAT_OFF_BAUDCTL, 8'h18);
        // Pin level is registered one edge behind the control write
        @(posedge clk_i);
        #1;
        pol = 1'b1;
        chk("inverted idle", 16'h0000, {15'h0000, serial_out_o});
        send(8'h5A);
        rx(7, 9'h05A);
        do @(posedge clk_i); while (baud_tick_i !== 1'b1);
        wr(UAT_OFF_TXCTL, 8'h34);
        @(posedge clk_i);
        #1;
        pol = 1'b0;
        chk("sync line", 16'h0001, {15'h0000, serial_out_o});
        rdchk(UAT_OFF_IRQ_FLG, 8'h00, "flag sync");
        send(8'h77);
        repeat (150) @(posedge clk_i);
        chk("sync dropped", 16'h0007, 16'(rxq.size()));
        wr(UAT_OFF_PORTCTL, 8'h00);
        @(posedge clk_i);
        #1;
        chk("pin released", 16'h0001, {15'h0000, serial_out_oe_b_o});
        summarize();
    end
endmodule
